//--- rtl/event_code_reporter.sv
// Event code reporter: sticky event bits, mask, pending code readout, AXI4-Lite slave.
// Assumes event pulses are synchronous to clk and last one cycle each.
// Function
// R1 - Ack timeout after non-broadcast packet raises 91; broadcast never does.
// R2 - Each acknowledge sent raises A1.
// R3 - Non-root node receiving cycle start raises B1 and starts iso cycle.
// R4 - Iso cycle flag set to one in the same cycle as B1.
// R5 - Root node sending cycle start raises B2.
// R6 - Async packet into data buffer raises C1 and shows its header.
// R7 - Last chain transaction raises C2 and suppresses C1 for it.
// R8 - C2 bypasses the interrupt mask.
// R9 - Mode bit 3 selects C2 reporting for one-transaction chains.
// R10 - Each completed write-chain transaction raises C3, ack_complete included.
// R11 - Write response received with its ack sent also raises C3.
// R12 - PHY packet sent raises D1 config, D2 link-on, D3 ping.
// R13 - Physical configuration packet received raises E1.
// R14 - Received config goes into physical register 1 and sets mode.
// R15 - Link-on packet to this node raises E2 and asserts link-on pin.
// R16 - Self-ID after ping raises E3 and is stored in receive FIFO.
// R17 - Code and interrupt stay pending until the host reads the code; a W1C write to status also clears them.
//
// Implementation choices: the address map and the AXI4-Lite slave port.
`timescale 1ns/1ns
`default_nettype none
module event_code_reporter #(
  parameter int unsigned HDR_W = evrep_pkg::DATA_W
) (
  input  wire logic                            clk,
  input  wire logic                            rst_n,
  input  wire evrep_pkg::ev_in_t               ev,
  input  wire logic [HDR_W-1:0]                rx_header,
  output logic                                 irq,
  output logic                                 link_on_indication_output,
  output logic                                 iso_cycle_start,
  output logic                                 sid_store,
  output logic [evrep_pkg::PHY_W-1:0]          phy_mode,
  input  wire logic [evrep_pkg::ADDR_W-1:0]    s_axi_awaddr,
  input  wire logic                            s_axi_awvalid,
  output logic                                 s_axi_awready,
  input  wire logic [evrep_pkg::DATA_W-1:0]    s_axi_wdata,
  input  wire logic [evrep_pkg::DATA_W/8-1:0]  s_axi_wstrb,
  input  wire logic                            s_axi_wvalid,
  output logic                                 s_axi_wready,
  output logic [1:0]                           s_axi_bresp,
  output logic                                 s_axi_bvalid,
  input  wire logic                            s_axi_bready,
  input  wire logic [evrep_pkg::ADDR_W-1:0]    s_axi_araddr,
  input  wire logic                            s_axi_arvalid,
  output logic                                 s_axi_arready,
  output logic [evrep_pkg::DATA_W-1:0]         s_axi_rdata,
  output logic [1:0]                           s_axi_rresp,
  output logic                                 s_axi_rvalid,
  input  wire logic                            s_axi_rready
);
  localparam int unsigned N  = evrep_pkg::NUM_EV;
  localparam int unsigned DW = evrep_pkg::DATA_W;

  logic [N-1:0]                 status_q;
  logic [N-1:0]                 mask_q;
  logic [evrep_pkg::MODE_W-1:0] mode_q;
  logic                         iso_q;
  logic [HDR_W-1:0]             hdr_q;
  logic [N-1:0]                 set_ev;
  logic [N-1:0]                 clr_ev;
  logic [N-1:0]                 pend_sel;
  logic [evrep_pkg::CODE_W-1:0] pend_code;
  logic                         rtxn_last;
  logic                         c2_hit;
  logic                         wr_txn;

  // AXI write side holding registers
  logic                         aw_have_q;
  logic                         w_have_q;
  logic [evrep_pkg::ADDR_W-1:0] awaddr_q;
  logic [DW-1:0]                wdata_q;
  logic                         wr_fire;
  logic                         rd_fire;

  // R9 single transaction reporting
  assign rtxn_last = ev.chain_active & ev.chain_last;
  assign c2_hit    = rtxn_last & (~ev.chain_single | mode_q[evrep_pkg::MODE_SINGLE_C2]);
  assign wr_txn    = ev.chain_active & ev.wr_chain & (ev.ack_complete | ev.wr_resp_acked);

  always_comb begin
    set_ev = '0;
    // R1 broadcast excluded
    set_ev[evrep_pkg::EV_ACK_MISS]   = ev.ack_timeout & ~ev.tx_broadcast;
    // R2 ack sent
    set_ev[evrep_pkg::EV_ACK_SENT]   = ev.ack_sent;
    // R3 non-root cycle start
    set_ev[evrep_pkg::EV_CYC_RX]     = ev.cyc_rx_ok & ~ev.is_root;
    // R5 root cycle start
    set_ev[evrep_pkg::EV_CYC_TX]     = ev.cyc_tx & ev.is_root;
    // R6 R7 C1 yields to C2
    set_ev[evrep_pkg::EV_ASYNC_RX]   = ev.async_rx_ok & ~c2_hit;
    set_ev[evrep_pkg::EV_CHAIN_DONE] = c2_hit & (ev.async_rx_ok | wr_txn);
    // R10 R11 per write transaction
    set_ev[evrep_pkg::EV_WR_TXN]     = wr_txn;
    // R12 PHY packet kinds
    set_ev[evrep_pkg::EV_PHY_CFG_TX] = ev.phy_tx_done & (ev.phy_tx_kind == evrep_pkg::PHY_CFG);
    set_ev[evrep_pkg::EV_LINK_ON_TX] =
      ev.phy_tx_done & (ev.phy_tx_kind == evrep_pkg::PHY_LINK_ON);
    set_ev[evrep_pkg::EV_PING_TX]    = ev.phy_tx_done & (ev.phy_tx_kind == evrep_pkg::PHY_PING);
    // R13 config received
    set_ev[evrep_pkg::EV_PHY_CFG_RX] = ev.phy_cfg_rx_ok;
    // R15 link-on received
    set_ev[evrep_pkg::EV_LINK_ON_RX] = ev.link_on_rx_self;
    // R16 self-ID after ping
    set_ev[evrep_pkg::EV_SID_RX]     = ev.sid_after_ping_ok;
  end

  // Lowest pending slot is the code shown to the host
  always_comb begin
    pend_sel  = '0;
    pend_code = evrep_pkg::CODE_NONE;
    for (int i = N - 1; i >= 0; i--) begin
      if (status_q[i]) begin
        pend_sel  = '0;
        pend_sel[i] = 1'b1;
        pend_code = evrep_pkg::EV_CODES[i*evrep_pkg::CODE_W +: evrep_pkg::CODE_W];
      end
    end
  end

  // Clears from status W1C writes and from code reads
  always_comb begin
    clr_ev = '0;
    if (wr_fire && awaddr_q == evrep_pkg::OFF_STATUS) begin
      clr_ev = wdata_q[N-1:0];
    end
    if (rd_fire && s_axi_araddr == evrep_pkg::OFF_CODE) begin
      clr_ev = clr_ev | pend_sel;
    end
  end

  // R17 sticky until code read or status W1C write; set beats clear
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      status_q <= '0;
    end else begin
      status_q <= (status_q & ~clr_ev) | set_ev;
    end
  end

  // R8 chain done ignores mask
  always_comb begin
    logic [N-1:0] en;
    en = mask_q;
    en[evrep_pkg::EV_CHAIN_DONE] = 1'b1;
    irq = |(status_q & en);
  end

  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      mask_q <= evrep_pkg::MASK_RST;
      mode_q <= evrep_pkg::MODE_RST;
    end else if (wr_fire) begin
      if (awaddr_q == evrep_pkg::OFF_MASK) begin
        mask_q <= wdata_q[N-1:0];
      end else if (awaddr_q == evrep_pkg::OFF_MODE) begin
        mode_q <= wdata_q[evrep_pkg::MODE_W-1:0];
      end
    end
  end

  // R3 R4 iso flag with B1; host W1C, set wins
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      iso_q           <= 1'b0;
      iso_cycle_start <= 1'b0;
    end else begin
      iso_cycle_start <= set_ev[evrep_pkg::EV_CYC_RX];
      if (set_ev[evrep_pkg::EV_CYC_RX]) begin
        iso_q <= 1'b1;
      end else if (wr_fire && awaddr_q == evrep_pkg::OFF_FLAGS
                   && wdata_q[evrep_pkg::FLAG_ISO]) begin
        iso_q <= 1'b0;
      end
    end
  end

  // R15 link-on pin held until host clears it
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      link_on_indication_output <= 1'b0;
    end else if (ev.link_on_rx_self) begin
      link_on_indication_output <= 1'b1;
    end else if (wr_fire && awaddr_q == evrep_pkg::OFF_FLAGS
                 && wdata_q[evrep_pkg::FLAG_LINK_ON]) begin
      link_on_indication_output <= 1'b0;
    end
  end

  // R14 physical register 1 drives the mode
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      phy_mode <= '0;
    end else if (ev.phy_cfg_rx_ok) begin
      phy_mode <= ev.phy_cfg_data;
    end
  end

  // R6 header display capture
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      hdr_q <= '0;
    end else if (ev.async_rx_ok) begin
      hdr_q <= rx_header;
    end
  end

  // R16 store strobe to the receive FIFO
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      sid_store <= 1'b0;
    end else begin
      sid_store <= ev.sid_after_ping_ok;
    end
  end

  // Write channel: address and data taken in either order
  assign s_axi_awready = ~aw_have_q & ~s_axi_bvalid;
  assign s_axi_wready  = ~w_have_q & ~s_axi_bvalid;
  assign wr_fire       = aw_have_q & w_have_q & ~s_axi_bvalid;

  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      aw_have_q    <= 1'b0;
      w_have_q     <= 1'b0;
      awaddr_q     <= '0;
      wdata_q      <= '0;
      s_axi_bvalid <= 1'b0;
      s_axi_bresp  <= evrep_pkg::RESP_OKAY;
    end else begin
      if (s_axi_awvalid && s_axi_awready) begin
        aw_have_q <= 1'b1;
        awaddr_q  <= s_axi_awaddr;
      end
      if (s_axi_wvalid && s_axi_wready) begin
        w_have_q <= 1'b1;
        // Byte lanes with strobe low write zero; W1C bits then stay put
        for (int b = 0; b < DW / 8; b++) begin
          wdata_q[b*8 +: 8] <= s_axi_wstrb[b] ? s_axi_wdata[b*8 +: 8] : 8'h00;
        end
      end
      if (wr_fire) begin
        aw_have_q    <= 1'b0;
        w_have_q     <= 1'b0;
        s_axi_bvalid <= 1'b1;
        if (awaddr_q == evrep_pkg::OFF_STATUS || awaddr_q == evrep_pkg::OFF_MASK
            || awaddr_q == evrep_pkg::OFF_FLAGS || awaddr_q == evrep_pkg::OFF_MODE) begin
          s_axi_bresp <= evrep_pkg::RESP_OKAY;
        end else begin
          s_axi_bresp <= evrep_pkg::RESP_SLVERR;
        end
      end else if (s_axi_bready) begin
        s_axi_bvalid <= 1'b0;
      end
    end
  end

  // Read channel: one cycle latency; code read pops the shown event
  assign s_axi_arready = ~s_axi_rvalid;
  assign rd_fire       = s_axi_arvalid & s_axi_arready;

  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      s_axi_rvalid <= 1'b0;
      s_axi_rdata  <= '0;
      s_axi_rresp  <= evrep_pkg::RESP_OKAY;
    end else if (rd_fire) begin
      s_axi_rvalid <= 1'b1;
      s_axi_rresp  <= evrep_pkg::RESP_OKAY;
      s_axi_rdata  <= '0;
      if (s_axi_araddr == evrep_pkg::OFF_STATUS) begin
        s_axi_rdata[N-1:0] <= status_q;
      end else if (s_axi_araddr == evrep_pkg::OFF_MASK) begin
        s_axi_rdata[N-1:0] <= mask_q;
      end else if (s_axi_araddr == evrep_pkg::OFF_CODE) begin
        // R17 host read services the event
        s_axi_rdata[evrep_pkg::CODE_W-1:0] <= pend_code;
      end else if (s_axi_araddr == evrep_pkg::OFF_FLAGS) begin
        s_axi_rdata[evrep_pkg::FLAG_ISO]     <= iso_q;
        s_axi_rdata[evrep_pkg::FLAG_LINK_ON] <= link_on_indication_output;
      end else if (s_axi_araddr == evrep_pkg::OFF_MODE) begin
        s_axi_rdata[evrep_pkg::MODE_W-1:0] <= mode_q;
      end else if (s_axi_araddr == evrep_pkg::OFF_PHY1) begin
        s_axi_rdata[evrep_pkg::PHY_W-1:0] <= phy_mode;
      end else if (s_axi_araddr == evrep_pkg::OFF_RXHDR) begin
        s_axi_rdata[HDR_W-1:0] <= hdr_q;
      end else begin
        s_axi_rresp <= evrep_pkg::RESP_SLVERR;
      end
    end else if (s_axi_rready) begin
      s_axi_rvalid <= 1'b0;
    end
  end

  default clocking cb @(posedge clk); endclocking
  default disable iff (!rst_n);

  sequence s_bcast_timeout;
    ev.ack_timeout && ev.tx_broadcast && !status_q[evrep_pkg::EV_ACK_MISS];
  endsequence

  sequence s_read_code;
    rd_fire && s_axi_araddr == evrep_pkg::OFF_CODE && |status_q;
  endsequence

  ack_miss_gate_a: assert property ( // R1
    s_bcast_timeout |=> !status_q[evrep_pkg::EV_ACK_MISS] || $past(status_q[evrep_pkg::EV_ACK_MISS]))
    else $error("broadcast timeout raised code 91");

  ack_sent_set_a: assert property ( // R2
    ev.ack_sent |=> status_q[evrep_pkg::EV_ACK_SENT])
    else $error("ack sent not recorded");

  iso_flag_sync_a: assert property ( // R4
    ev.cyc_rx_ok && !ev.is_root |=> iso_q && status_q[evrep_pkg::EV_CYC_RX] && iso_cycle_start)
    else $error("iso flag not set with B1");

  root_cyc_only_a: assert property ( // R5
    ev.cyc_tx && !ev.is_root && !status_q[evrep_pkg::EV_CYC_TX]
    |=> !status_q[evrep_pkg::EV_CYC_TX])
    else $error("B2 raised by non-root");

  chain_c1_excl_a: assert property ( // R7
    ev.async_rx_ok && rtxn_last && !ev.chain_single && !status_q[evrep_pkg::EV_ASYNC_RX]
    |=> status_q[evrep_pkg::EV_CHAIN_DONE] && !status_q[evrep_pkg::EV_ASYNC_RX])
    else $error("C1 reported for last chain transaction");

  c2_unmasked_a: assert property ( // R8
    status_q[evrep_pkg::EV_CHAIN_DONE] |-> irq)
    else $error("C2 masked");

  phy_reg_load_a: assert property ( // R14
    ev.phy_cfg_rx_ok |=> phy_mode == $past(ev.phy_cfg_data) && status_q[evrep_pkg::EV_PHY_CFG_RX])
    else $error("physical register 1 not loaded");

  link_on_pin_a: assert property ( // R15
    ev.link_on_rx_self |=> link_on_indication_output ##1 (link_on_indication_output
      || $past(wr_fire && awaddr_q == evrep_pkg::OFF_FLAGS && wdata_q[evrep_pkg::FLAG_LINK_ON])))
    else $error("link-on pin not asserted");

  sid_store_a: assert property ( // R16
    ev.sid_after_ping_ok |=> sid_store && status_q[evrep_pkg::EV_SID_RX])
    else $error("self-ID not stored");

  code_pop_a: assert property ( // R17
    s_read_code |=> s_axi_rvalid && s_axi_rdata[evrep_pkg::CODE_W-1:0] != evrep_pkg::CODE_NONE)
    else $error("pending code not returned");

  pend_hold_a: assert property ( // R17
    |status_q && !rd_fire && !wr_fire |=> |status_q)
    else $error("event dropped without host read");

  hdr_capture_a: assert property ( // R6
    ev.async_rx_ok |=> hdr_q == $past(rx_header))
    else $error("receive header not captured");

  single_c2_mode_a: assert property ( // R9
    ev.async_rx_ok && rtxn_last && ev.chain_single && !mode_q[evrep_pkg::MODE_SINGLE_C2]
    && !status_q[evrep_pkg::EV_CHAIN_DONE] |=> !status_q[evrep_pkg::EV_CHAIN_DONE]
    && status_q[evrep_pkg::EV_ASYNC_RX])
    else $error("single chain with mode bit clear raised C2");

  wr_txn_c3_a: assert property ( // R10 R11
    ev.chain_active && ev.wr_chain && (ev.ack_complete || ev.wr_resp_acked)
    |=> status_q[evrep_pkg::EV_WR_TXN])
    else $error("write transaction did not raise C3");

  ping_sent_a: assert property ( // R12
    ev.phy_tx_done && ev.phy_tx_kind == evrep_pkg::PHY_PING
    |=> status_q[evrep_pkg::EV_PING_TX])
    else $error("ping sent did not raise D3");

endmodule // event_code_reporter
`default_nettype wire

//--- rtl/evrep_pkg.sv
// Package for the serial bus event code reporter.
// Assumes a single 250 MHz clock and that event pulses come from same-clock link logic.
package evrep_pkg;
  localparam int unsigned DATA_W   = 32;
  localparam int unsigned ADDR_W   = 8;
  localparam int unsigned NUM_EV   = 13;
  localparam int unsigned CODE_W   = 8;
  localparam int unsigned PHY_W    = 16;
  localparam int unsigned MODE_W   = 8;

  // Register byte offsets
  localparam logic [ADDR_W-1:0] OFF_STATUS = 8'h00;
  localparam logic [ADDR_W-1:0] OFF_MASK   = 8'h04;
  localparam logic [ADDR_W-1:0] OFF_CODE   = 8'h08;
  localparam logic [ADDR_W-1:0] OFF_FLAGS  = 8'h0c;
  localparam logic [ADDR_W-1:0] OFF_MODE   = 8'h10;
  localparam logic [ADDR_W-1:0] OFF_PHY1   = 8'h14;
  localparam logic [ADDR_W-1:0] OFF_RXHDR  = 8'h18;

  // Field positions
  localparam int unsigned FLAG_ISO      = 0;
  localparam int unsigned FLAG_LINK_ON  = 1;
  localparam int unsigned MODE_SINGLE_C2 = 3;

  localparam logic [NUM_EV-1:0] MASK_RST = 13'h0000;
  localparam logic [MODE_W-1:0] MODE_RST = 8'h00;
  localparam logic [1:0] RESP_OKAY   = 2'h0;
  localparam logic [1:0] RESP_SLVERR = 2'h2;
  localparam logic [CODE_W-1:0] CODE_NONE = 8'h00;

  // Event slots, lowest index wins when several are pending
  typedef enum int unsigned {
    EV_ACK_MISS, EV_ACK_SENT, EV_CYC_RX, EV_CYC_TX, EV_ASYNC_RX, EV_CHAIN_DONE,
    EV_WR_TXN, EV_PHY_CFG_TX, EV_LINK_ON_TX, EV_PING_TX, EV_PHY_CFG_RX,
    EV_LINK_ON_RX, EV_SID_RX
  } ev_idx_t;

  localparam logic [NUM_EV*CODE_W-1:0] EV_CODES = {
    8'he3, 8'he2, 8'he1, 8'hd3, 8'hd2, 8'hd1, 8'hc3, 8'hc2, 8'hc1, 8'hb2, 8'hb1,
    8'ha1, 8'h91};

  typedef enum logic [1:0] {PHY_CFG = 2'h0, PHY_LINK_ON = 2'h1, PHY_PING = 2'h2} phy_kind_t;

  // One-cycle event pulses and qualifiers from the link core
  typedef struct packed {
    logic             ack_timeout;
    logic             tx_broadcast;
    logic             ack_sent;
    logic             cyc_rx_ok;
    logic             cyc_tx;
    logic             is_root;
    logic             async_rx_ok;
    logic             chain_active;
    logic             chain_last;
    logic             chain_single;
    logic             wr_chain;
    logic             ack_complete;
    logic             wr_resp_acked;
    logic             phy_tx_done;
    phy_kind_t        phy_tx_kind;
    logic             phy_cfg_rx_ok;
    logic [PHY_W-1:0] phy_cfg_data;
    logic             link_on_rx_self;
    logic             sid_after_ping_ok;
  } ev_in_t;
endpackage

//--- testbench/link_core_model.sv
// Link core stand-in: turns a numbered request into one event pulse with its qualifiers.
// Assumes req is high for one clk cycle; the pulse follows one cycle later.
`timescale 1ns/1ns
`default_nettype none
module link_core_model (
  input  wire logic        clk,
  input  wire logic        rst_n,
  input  wire logic        req,
  input  wire logic [4:0]  kind,
  output evrep_pkg::ev_in_t ev
);
  // Qualifiers ride only in the pulse cycle, as the real core gives them
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      ev <= '0;
    end else begin
      ev <= '0;
      ev.phy_tx_kind <= evrep_pkg::phy_kind_t'(2'h3);
      if (req) begin
        case (kind)
          5'd0: ev.ack_timeout <= 1'b1;
          5'd1: begin
            ev.ack_timeout <= 1'b1;
            ev.tx_broadcast <= 1'b1;
          end
          5'd2: ev.ack_sent <= 1'b1;
          5'd3: ev.cyc_rx_ok <= 1'b1;
          5'd4: begin
            ev.cyc_rx_ok <= 1'b1;
            ev.is_root <= 1'b1;
          end
          5'd5: begin
            ev.cyc_tx <= 1'b1;
            ev.is_root <= 1'b1;
          end
          5'd6: ev.async_rx_ok <= 1'b1;
          5'd7, 5'd8: begin
            ev.async_rx_ok <= 1'b1;
            ev.chain_active <= 1'b1;
            ev.chain_last <= 1'b1;
            ev.chain_single <= (kind == 5'd8);
          end
          5'd9, 5'd10: begin
            ev.ack_complete <= (kind == 5'd9);
            ev.wr_resp_acked <= (kind == 5'd10);
            ev.chain_active <= 1'b1;
            ev.chain_last <= (kind == 5'd9);
            ev.wr_chain <= 1'b1;
          end
          5'd11, 5'd12, 5'd13: begin
            ev.phy_tx_done <= 1'b1;
            ev.phy_tx_kind <= evrep_pkg::phy_kind_t'(kind - 5'd11);
          end
          5'd14: begin
            ev.phy_cfg_rx_ok <= 1'b1;
            ev.phy_cfg_data <= 16'h5a3c;
          end
          5'd15: ev.link_on_rx_self <= 1'b1;
          5'd16: ev.sid_after_ping_ok <= 1'b1;
          5'd17: ev.cyc_tx <= 1'b1;
          default: ev.ack_sent <= 1'b0;
        endcase
      end
    end
  end
endmodule // link_core_model
`default_nettype wire

//--- testbench/tb.sv
// Bench for the event code reporter: events via the link model, host over AXI4-Lite.
// Assumes the register map and status bit order given with the design.
`timescale 1ns/1ns
`default_nettype none
module tb;
  logic              clk = 1'b0;
  logic              rst_n = 1'b0;
  logic              req = 1'b0;
  logic [4:0]        kind = 5'h00;
  logic [31:0]       rx_header = 32'h00000000;
  evrep_pkg::ev_in_t ev;
  logic              irq;
  logic              lo_pin;
  logic              iso_pulse;
  logic              sid_pulse;
  logic [15:0]       phy_mode;
  logic [7:0]        s_axi_awaddr = 8'h00;
  logic [7:0]        s_axi_araddr = 8'h00;
  logic [31:0]       s_axi_wdata = 32'h00000000;
  logic [31:0]       s_axi_rdata;
  logic [3:0]        s_axi_wstrb = 4'h0;
  logic              s_axi_awvalid = 1'b0, s_axi_wvalid = 1'b0, s_axi_bready = 1'b0;
  logic              s_axi_arvalid = 1'b0, s_axi_rready = 1'b0;
  logic              s_axi_awready, s_axi_wready, s_axi_bvalid, s_axi_arready, s_axi_rvalid;
  logic [1:0]        s_axi_bresp, s_axi_rresp, r;
  logic [31:0]       d;
  int                num_errors = 0, n_compared = 0, cycles = 0, iso_cnt = 0, sid_cnt = 0;
  logic [7:0] ex_a [18] = '{8'h91, 8'h00, 8'ha1, 8'hb1, 8'h00, 8'hb2, 8'hc1, 8'hc2, 8'hc1,
                            8'hc2, 8'hc3, 8'hd1, 8'hd2, 8'hd3, 8'he1, 8'he2, 8'he3, 8'h00};

  always #2 clk = ~clk;

  link_core_model link_model (.clk(clk), .rst_n(rst_n), .req(req), .kind(kind), .ev(ev));

  event_code_reporter dut (.clk(clk), .rst_n(rst_n), .ev(ev), .rx_header(rx_header),
    .irq(irq), .link_on_indication_output(lo_pin), .iso_cycle_start(iso_pulse),
    .sid_store(sid_pulse), .phy_mode(phy_mode), .s_axi_awaddr(s_axi_awaddr),
    .s_axi_awvalid(s_axi_awvalid), .s_axi_awready(s_axi_awready), .s_axi_wdata(s_axi_wdata),
    .s_axi_wstrb(s_axi_wstrb), .s_axi_wvalid(s_axi_wvalid), .s_axi_wready(s_axi_wready),
    .s_axi_bresp(s_axi_bresp), .s_axi_bvalid(s_axi_bvalid), .s_axi_bready(s_axi_bready),
    .s_axi_araddr(s_axi_araddr), .s_axi_arvalid(s_axi_arvalid),
    .s_axi_arready(s_axi_arready), .s_axi_rdata(s_axi_rdata), .s_axi_rresp(s_axi_rresp),
    .s_axi_rvalid(s_axi_rvalid), .s_axi_rready(s_axi_rready));

  task automatic tally_and_finish;
    $display("compared %0d, mismatches %0d", n_compared, num_errors);
    if (num_errors == 0 && n_compared > 0) begin
      $display("ALL CHECKS OK");
    end else begin
      $display("CHECKS NOT OK");
    end
    $finish;
  endtask

  // Cuts a hang short; the whole run needs well under a thousand cycles
  always @(posedge clk) begin
    cycles <= cycles + 1;
    if (cycles == 5000) begin
      num_errors = num_errors + 1;
      tally_and_finish();
    end
  end

  always @(posedge clk) begin
    if (iso_pulse === 1'b1) iso_cnt <= iso_cnt + 1;
    if (sid_pulse === 1'b1) sid_cnt <= sid_cnt + 1;
  end

  task automatic chk_val(input logic [31:0] got, input logic [31:0] exp);
    n_compared++;
    if (got !== exp) begin
      num_errors++;
      $display("unexpected value at %0t: got %h, expected %h", $time, got, exp);
    end
  endtask

  task automatic chk_resp(input logic [1:0] got, input logic [1:0] exp);
    n_compared++;
    if (got !== exp) begin
      num_errors++;
      $display("unexpected response at %0t: got %h, expected %h", $time, got, exp);
    end
  endtask

  task automatic axw(input logic [7:0] a, input logic [31:0] dd, input logic [3:0] st,
                     output logic [1:0] rsp);
    logic aw_ok;
    logic w_ok;
    aw_ok = 1'b0;
    w_ok = 1'b0;
    s_axi_awaddr <= a;
    s_axi_wdata <= dd;
    s_axi_wstrb <= st;
    s_axi_awvalid <= 1'b1;
    s_axi_wvalid <= 1'b1;
    while (!(aw_ok && w_ok)) begin
      @(posedge clk);
      if (!aw_ok && s_axi_awready === 1'b1) begin
        aw_ok = 1'b1;
        s_axi_awvalid <= 1'b0;
      end
      if (!w_ok && s_axi_wready === 1'b1) begin
        w_ok = 1'b1;
        s_axi_wvalid <= 1'b0;
      end
    end
    s_axi_bready <= 1'b1;
    do @(posedge clk); while (s_axi_bvalid !== 1'b1);
    rsp = s_axi_bresp;
    s_axi_bready <= 1'b0;
  endtask

  task automatic axr(input logic [7:0] a, output logic [31:0] dd, output logic [1:0] rsp);
    s_axi_araddr <= a;
    s_axi_arvalid <= 1'b1;
    do @(posedge clk); while (s_axi_arready !== 1'b1);
    s_axi_arvalid <= 1'b0;
    s_axi_rready <= 1'b1;
    do @(posedge clk); while (s_axi_rvalid !== 1'b1);
    dd = s_axi_rdata;
    rsp = s_axi_rresp;
    s_axi_rready <= 1'b0;
  endtask

  // Status and irq have settled three cycles after the request
  task automatic pulse(input logic [4:0] k);
    kind <= k;
    req <= 1'b1;
    @(posedge clk);
    req <= 1'b0;
    repeat (3) @(posedge clk);
  endtask

  initial begin
    repeat (20) @(posedge clk);
    rst_n <= 1'b1;
    @(posedge clk);
    axr(evrep_pkg::OFF_MASK, d, r);
    chk_val(d, 32'h00000000);
    axw(evrep_pkg::OFF_MASK, 32'h00001fff, 4'h1, r);
    axr(evrep_pkg::OFF_MASK, d, r);
    chk_val(d, 32'h000000ff);
    axw(evrep_pkg::OFF_MASK, 32'h00001fff, 4'hf, r);
    chk_resp(r, evrep_pkg::RESP_OKAY);
    rx_header <= 32'hc0de1234;
    for (int k = 0; k < 18; k++) begin
      pulse(5'(k));
      chk_val({31'h0, irq}, {31'h0, ex_a[k] != 8'h00});
      axr(evrep_pkg::OFF_CODE, d, r);
      chk_val(d, {24'h0, ex_a[k]});
      axr(evrep_pkg::OFF_CODE, d, r);
      chk_val(d, (k == 9) ? 32'h000000c3 : 32'h00000000);
      chk_val({31'h0, irq}, 32'h00000000);
    end
    axr(evrep_pkg::OFF_FLAGS, d, r);
    chk_val(d, 32'h00000003);
    chk_val({31'h0, lo_pin}, 32'h00000001);
    axw(evrep_pkg::OFF_FLAGS, 32'h00000003, 4'hf, r);
    chk_val({31'h0, lo_pin}, 32'h00000000);
    axr(evrep_pkg::OFF_RXHDR, d, r);
    chk_val(d, 32'hc0de1234);
    axr(evrep_pkg::OFF_PHY1, d, r);
    chk_val(d, 32'h00005a3c);
    chk_val({16'h0, phy_mode}, 32'h00005a3c);
    chk_val(iso_cnt, 32'h00000001);
    chk_val(sid_cnt, 32'h00000001);
    axw(evrep_pkg::OFF_MODE, 32'h00000008, 4'hf, r);
    pulse(5'd8);
    axr(evrep_pkg::OFF_CODE, d, r);
    chk_val(d, 32'h000000c2);
    axr(evrep_pkg::OFF_CODE, d, r);
    chk_val(d, 32'h00000000);
    axw(evrep_pkg::OFF_MASK, 32'h00000000, 4'hf, r);
    pulse(5'd2);
    chk_val({31'h0, irq}, 32'h00000000);
    pulse(5'd7);
    chk_val({31'h0, irq}, 32'h00000001);
    axr(evrep_pkg::OFF_STATUS, d, r);
    chk_val(d, 32'h00000022);
    axw(evrep_pkg::OFF_STATUS, 32'h00000022, 4'hf, r);
    axr(evrep_pkg::OFF_STATUS, d, r);
    chk_val(d, 32'h00000000);
    chk_val({31'h0, irq}, 32'h00000000);
    axw(evrep_pkg::OFF_CODE, 32'h000000ff, 4'hf, r);
    chk_resp(r, evrep_pkg::RESP_SLVERR);
    axr(8'h40, d, r);
    chk_resp(r, evrep_pkg::RESP_SLVERR);
    chk_val(d, 32'h00000000);
    tally_and_finish();
  end
endmodule // tb
`default_nettype wire
